// ---- src/dds_regs_pkg.sv ----
package dds_regs_pkg;

  localparam int NUM_CHAN = 2;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int NUM_PROF = 15;
  localparam int PROF_IDX_W = 4;

  // Register addresses shared by both channel copies.
  localparam logic [4:0] ADDR_CHAN_SEL = 5'h00;
  localparam logic [4:0] ADDR_CHAN_FUNC = 5'h03;
  localparam logic [4:0] ADDR_FTW = 5'h04;
  localparam logic [4:0] ADDR_POW = 5'h05;
  localparam logic [4:0] ADDR_AMP_CTRL = 5'h06;
  localparam logic [4:0] ADDR_SRR = 5'h07;
  localparam logic [4:0] ADDR_RISE_STEP = 5'h08;
  localparam logic [4:0] ADDR_FALL_STEP = 5'h09;
  localparam logic [4:0] ADDR_PROF_FIRST = 5'h0A;
  localparam logic [4:0] ADDR_PROF_LAST = 5'h18;

  // Field positions.
  localparam int SEL_EN_LSB = 6;
  localparam int SEL_EN_MSB = 7;
  localparam int FUNC_PHASE_CLR_BIT = 1;
  localparam int POW_W = 14;
  localparam int SRR_RISE_LSB = 0;
  localparam int SRR_FALL_LSB = 8;
  localparam int RATE_W = 8;

  // Reset values.
  localparam logic [7:0] SEL_RESET = 8'hC0;
  localparam logic [23:0] FUNC_RESET = 24'h000302;
  localparam logic [31:0] FTW_RESET = 32'h00000000;
  localparam logic [15:0] POW_RESET = 16'h0000;
  localparam logic [23:0] AMP_RESET = 24'h000000;
  localparam logic [15:0] SRR_RESET = 16'h0000;
  localparam logic [31:0] STEP_RESET = 32'h00000000;
  localparam logic [31:0] PROF_RESET = 32'h00000000;

  typedef struct packed {
    logic [23:0] channel_function_control;
    logic [31:0] frequency_tuning_word;
    logic [15:0] phase_offset_word;
    logic [23:0] amplitude_control;
    logic [15:0] sweep_ramp_rate;
    logic [31:0] rising_sweep_step;
    logic [31:0] falling_sweep_step;
  } dds_chan_cfg_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dds_wr_req_t;

  localparam dds_chan_cfg_t CHAN_CFG_RESET = '{
    channel_function_control: FUNC_RESET,
    frequency_tuning_word: FTW_RESET,
    phase_offset_word: POW_RESET,
    amplitude_control: AMP_RESET,
    sweep_ramp_rate: SRR_RESET,
    rising_sweep_step: STEP_RESET,
    falling_sweep_step: STEP_RESET
  };

  function automatic logic dds_is_prof_addr(input logic [ADDR_W-1:0] a);
    dds_is_prof_addr = (a >= ADDR_PROF_FIRST) && (a <= ADDR_PROF_LAST);
  endfunction : dds_is_prof_addr

  function automatic logic [PROF_IDX_W-1:0] dds_prof_index(
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] d;
    d = a - ADDR_PROF_FIRST;
    dds_prof_index = d[PROF_IDX_W-1:0];
  endfunction : dds_prof_index

endpackage : dds_regs_pkg

// ---- src/dds_profile_store.sv ----
`timescale 1ns/100ps
module dds_profile_store
  import dds_regs_pkg::*;
(
  input wire logic i_sys_clk, // System clock.
  input wire logic i_reset, // Synchronous master reset.
  input wire logic i_we, // Write one profile word.
  input wire logic [PROF_IDX_W-1:0] i_wr_index, // Written word index.
  input wire logic [DATA_W-1:0] i_wr_data, // Written word.
  input wire logic i_io_update, // Transfer written words to active.
  input wire logic [PROF_IDX_W-1:0] i_rd_index, // Readback word index.
  output logic [DATA_W-1:0] o_rd_word, // Written copy at i_rd_index.
  output logic [NUM_PROF-1:0][DATA_W-1:0] o_active // Active words.
);
  import dds_regs_pkg::*;

  logic [DATA_W-1:0] shadow [NUM_PROF];
  logic [DATA_W-1:0] next_shadow [NUM_PROF];
  logic [NUM_PROF-1:0][DATA_W-1:0] next_active;

  always_comb begin
    for (int i = 0; i < NUM_PROF; i++) begin
      next_shadow[i] = shadow[i];
      next_active[i] = o_active[i];
      if (i_io_update) begin
        next_active[i] = shadow[i]; // R09
      end
      if (i_we && (i_wr_index == PROF_IDX_W'(i))) begin
        next_shadow[i] = i_wr_data;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      for (int i = 0; i < NUM_PROF; i++) begin
        shadow[i] <= PROF_RESET;
        o_active[i] <= PROF_RESET;
      end
    end else begin
      shadow <= next_shadow;
      o_active <= next_active;
    end
  end

  assign o_rd_word = (i_rd_index < PROF_IDX_W'(NUM_PROF)) ?
    shadow[i_rd_index] : '0;

endmodule : dds_profile_store

// ---- src/dds_channel_bank.sv ----
`timescale 1ns/100ps
// What this block does
// R01 - Two independent copies of every channel register.
// R02 - Both copies share one identical address.
// R03 - Writes land only in enabled channel copies.
// R04 - Master reset sets phase accumulator clear bit.
// R05 - I/O update self-clears phase accumulator clear bit.
// R06 - Phase offset fourteen bits, top two zero.
// R07 - Ramp rate: rising low byte, falling high.
// R08 - Enable field: 01 ch0, 10 ch1, 11 both.
// R09 - Values act at I/O update; enables immediately.
module dds_channel_bank
  import dds_regs_pkg::*;
(
  input wire logic i_sys_clk, // System clock, 200 MHz.
  input wire logic i_reset, // Synchronous master reset.
  input wire dds_wr_req_t i_wr, // Register write request.
  input wire logic i_rd_en, // Register read request.
  input wire logic [ADDR_W-1:0] i_rd_addr, // Register read address.
  input wire logic i_io_update, // I/O update pulse.
  output logic [DATA_W-1:0] o_rd_data, // Read data, one cycle later.
  output logic o_rd_valid, // Read data valid pulse.
  output logic [NUM_CHAN-1:0] o_chan_enable, // Live channel enables.
  output logic [7:0] o_chan_select, // Whole channel select byte.
  output dds_chan_cfg_t [NUM_CHAN-1:0] o_chan_cfg, // Active values.
  output logic [NUM_CHAN-1:0][NUM_PROF-1:0][DATA_W-1:0] o_prof_words // Active.
);
  import dds_regs_pkg::*;

  dds_chan_cfg_t [NUM_CHAN-1:0] shadow;
  dds_chan_cfg_t [NUM_CHAN-1:0] next_shadow;
  dds_chan_cfg_t [NUM_CHAN-1:0] next_active;
  logic [7:0] next_chan_select;
  logic [DATA_W-1:0] next_rd_data;
  logic next_rd_valid;
  logic [DATA_W-1:0] prof_rd_word [NUM_CHAN];
  logic [NUM_CHAN-1:0] prof_we;
  logic rd_chan;

  // Enable bits act the moment their byte is written, with no update.
  assign o_chan_enable = o_chan_select[SEL_EN_MSB:SEL_EN_LSB]; // R09

  // Readback shows one channel; software enables one at a time, so
  // channel 0 wins if both happen to be enabled.
  assign rd_chan = ~o_chan_enable[0];

  // Channel select byte.
  always_comb begin
    next_chan_select = o_chan_select;
    if (i_wr.valid && (i_wr.addr == ADDR_CHAN_SEL)) begin
      next_chan_select = i_wr.data[7:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_chan_select <= SEL_RESET;
    end else begin
      o_chan_select <= next_chan_select;
    end
  end

  // Per-channel control registers, written copy and active copy.
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      next_shadow[c] = shadow[c];
      next_active[c] = o_chan_cfg[c];
      if (i_io_update) begin
        next_active[c] = shadow[c]; // R09
        next_active[c].channel_function_control[FUNC_PHASE_CLR_BIT] =
          1'b0; // R05
        next_shadow[c].channel_function_control[FUNC_PHASE_CLR_BIT] =
          1'b0; // R05
      end
      // Address picks the register; only the enable bit picks the copy.
      if (i_wr.valid && o_chan_enable[c]) begin // R02 R03 R08
        if (i_wr.addr == ADDR_CHAN_FUNC) begin
          // A host write in the update cycle wins over the self-clear.
          next_shadow[c].channel_function_control = i_wr.data[23:0];
        end else if (i_wr.addr == ADDR_FTW) begin
          next_shadow[c].frequency_tuning_word = i_wr.data;
        end else if (i_wr.addr == ADDR_POW) begin
          next_shadow[c].phase_offset_word =
            {2'b00, i_wr.data[POW_W-1:0]}; // R06
        end else if (i_wr.addr == ADDR_AMP_CTRL) begin
          next_shadow[c].amplitude_control = i_wr.data[23:0];
        end else if (i_wr.addr == ADDR_SRR) begin
          next_shadow[c].sweep_ramp_rate = {
            i_wr.data[SRR_FALL_LSB +: RATE_W],
            i_wr.data[SRR_RISE_LSB +: RATE_W]
          }; // R07
        end else if (i_wr.addr == ADDR_RISE_STEP) begin
          next_shadow[c].rising_sweep_step = i_wr.data;
        end else if (i_wr.addr == ADDR_FALL_STEP) begin
          next_shadow[c].falling_sweep_step = i_wr.data;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        shadow[c] <= CHAN_CFG_RESET; // R04 R06
        o_chan_cfg[c] <= CHAN_CFG_RESET; // R04
      end
    end else begin
      shadow <= next_shadow; // R01
      o_chan_cfg <= next_active;
    end
  end

  // Profile words, one store per channel.
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_prof
    assign prof_we[c] = i_wr.valid && o_chan_enable[c] &&
      dds_is_prof_addr(i_wr.addr); // R03
    dds_profile_store u_store (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_we(prof_we[c]),
      .i_wr_index(dds_prof_index(i_wr.addr)),
      .i_wr_data(i_wr.data),
      .i_io_update(i_io_update),
      .i_rd_index(dds_prof_index(i_rd_addr)),
      .o_rd_word(prof_rd_word[c]),
      .o_active(o_prof_words[c])
    ); // R01
  end

  // Readback returns the written copy, so a value can be checked
  // before the update that makes it act.
  always_comb begin
    next_rd_valid = i_rd_en;
    next_rd_data = '0;
    if (i_rd_en) begin
      if (i_rd_addr == ADDR_CHAN_SEL) begin
        next_rd_data = {24'h000000, o_chan_select};
      end else if (i_rd_addr == ADDR_CHAN_FUNC) begin
        next_rd_data = {8'h00, shadow[rd_chan].channel_function_control};
      end else if (i_rd_addr == ADDR_FTW) begin
        next_rd_data = shadow[rd_chan].frequency_tuning_word;
      end else if (i_rd_addr == ADDR_POW) begin
        next_rd_data = {16'h0000, shadow[rd_chan].phase_offset_word};
      end else if (i_rd_addr == ADDR_AMP_CTRL) begin
        next_rd_data = {8'h00, shadow[rd_chan].amplitude_control};
      end else if (i_rd_addr == ADDR_SRR) begin
        next_rd_data = {16'h0000, shadow[rd_chan].sweep_ramp_rate};
      end else if (i_rd_addr == ADDR_RISE_STEP) begin
        next_rd_data = shadow[rd_chan].rising_sweep_step;
      end else if (i_rd_addr == ADDR_FALL_STEP) begin
        next_rd_data = shadow[rd_chan].falling_sweep_step;
      end else if (dds_is_prof_addr(i_rd_addr)) begin
        next_rd_data = prof_rd_word[rd_chan];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rd_data <= 32'h00000000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_data <= next_rd_data;
      o_rd_valid <= next_rd_valid;
    end
  end

endmodule : dds_channel_bank

// ---- bench/dds_bank_properties.sv ----
`timescale 1ns/100ps
module dds_bank_properties
  import dds_regs_pkg::*;
(
  input wire logic i_sys_clk, // Clock.
  input wire logic i_reset, // Reset.
  input wire dds_wr_req_t i_wr, // Write.
  input wire logic i_rd_en, // Read.
  input wire logic [ADDR_W-1:0] i_rd_addr, // Read address.
  input wire logic i_io_update, // Update.
  input wire logic [DATA_W-1:0] o_rd_data, // Read data.
  input wire logic o_rd_valid, // Read valid.
  input wire logic [NUM_CHAN-1:0] o_chan_enable, // Enables.
  input wire logic [7:0] o_chan_select, // Select byte.
  input wire dds_chan_cfg_t [NUM_CHAN-1:0] o_chan_cfg, // Active.
  input wire logic [NUM_CHAN-1:0][NUM_PROF-1:0][DATA_W-1:0]
    o_prof_words // Active profile words.
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_rd_answer: assert property (i_rd_en |=> o_rd_valid)
    else $error("read answer missing");
  a_rd_quiet: assert property (!i_rd_en |=>
    !o_rd_valid && o_rd_data == '0)
    else $error("read outputs not idle");
  a_rd_unmapped: assert property (i_rd_en && (i_rd_addr inside {5'h01, 5'h02}
    || i_rd_addr > ADDR_PROF_LAST) |=> o_rd_data == '0)
    else $error("unmapped read not zero");
  a_en_mirror: assert property (o_chan_enable == o_chan_select[7:6])
    else $error("enables differ from select byte");
  a_sel_now: assert property (i_wr.valid && i_wr.addr == ADDR_CHAN_SEL |=>
    o_chan_select == $past(i_wr.data[7:0]))
    else $error("select byte not live after write");
  a_cfg_hold: assert property (!i_io_update |=> $stable(o_chan_cfg))
    else $error("active values moved without update");
  a_prof_hold: assert property (!i_io_update |=> $stable(o_prof_words))
    else $error("profile words moved without update");
  a_clr_update: assert property (i_io_update |=>
    !o_chan_cfg[0].channel_function_control[1]
    && !o_chan_cfg[1].channel_function_control[1])
    else $error("phase clear bit kept after update");
  a_clr_reset: assert property ($fell(i_reset) |->
    o_chan_cfg[0].channel_function_control[1]
    && o_chan_cfg[1].channel_function_control[1])
    else $error("phase clear bit low after reset");
  a_pow_top: assert property (o_chan_cfg[0].phase_offset_word[15:14]
    == 2'h0 && o_chan_cfg[1].phase_offset_word[15:14] == 2'h0)
    else $error("phase offset top bits set");
endmodule : dds_bank_properties

bind dds_channel_bank dds_bank_properties dds_bank_properties_inst (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_wr(i_wr),
  .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .i_io_update(i_io_update),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
  .o_chan_enable(o_chan_enable), .o_chan_select(o_chan_select),
  .o_chan_cfg(o_chan_cfg), .o_prof_words(o_prof_words)
);

// ---- bench/dds_host_model.sv ----
`timescale 1ns/100ps
module dds_host_model
  import dds_regs_pkg::*;
(
  input wire logic i_sys_clk, // System clock.
  input wire logic i_rd_valid, // Read answer flag.
  input wire logic [DATA_W-1:0] i_rd_data, // Read answer word.
  output dds_wr_req_t o_wr, // Write request.
  output logic o_rd_en, // Read request.
  output logic [ADDR_W-1:0] o_rd_addr, // Read address.
  output logic o_io_update // Update pulse.
);
  initial begin
    o_wr = '0;
    o_rd_en = 1'b0;
    o_rd_addr = '0;
    o_io_update = 1'b0;
  end
  // Idle address and data are inverted so no stale word looks valid.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    #1;
    o_wr = '{valid: 1'b1, addr: a, data: d};
    @(posedge i_sys_clk);
    #1;
    o_wr = '{valid: 1'b0, addr: ~a, data: ~d};
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic v,
                    output logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    #1;
    o_rd_en = 1'b1;
    o_rd_addr = a;
    @(posedge i_sys_clk);
    #1;
    o_rd_en = 1'b0;
    o_rd_addr = ~a;
    v = i_rd_valid;
    d = i_rd_data;
  endtask : rd
  task automatic upd;
    @(posedge i_sys_clk);
    #1;
    o_io_update = 1'b1;
    @(posedge i_sys_clk);
    #1;
    o_io_update = 1'b0;
  endtask : upd
endmodule : dds_host_model

// ---- bench/dds_channel_bank_bench.sv ----
`timescale 1ns/100ps
module dds_channel_bank_bench;
  import dds_regs_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  dds_wr_req_t wr;
  logic rd_en;
  logic rd_valid;
  logic io_update;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic [7:0] chan_select;
  dds_chan_cfg_t [NUM_CHAN-1:0] cfg;
  logic [NUM_CHAN-1:0] chan_en;
  logic [NUM_CHAN-1:0][NUM_PROF-1:0][DATA_W-1:0] prof;
  logic [DATA_W-1:0] exp_step [NUM_CHAN];
  int err_count = 0;
  int n_compared = 0;
  always #2.5 sys_clk = ~sys_clk;
  dds_channel_bank dds_channel_bank_inst (.i_sys_clk(sys_clk),
    .i_reset(reset), .i_wr(wr), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
    .i_io_update(io_update), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_chan_enable(chan_en), .o_chan_select(chan_select), .o_chan_cfg(cfg),
    .o_prof_words(prof));
  dds_host_model dds_host_model_inst (.i_sys_clk(sys_clk),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_wr(wr), .o_rd_en(rd_en),
    .o_rd_addr(rd_addr), .o_io_update(io_update));
  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rdc(input string what, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] exp);
    logic v;
    logic [DATA_W-1:0] d;
    dds_host_model_inst.rd(a, v, d);
    check({what, " valid"}, {31'h00000000, v}, 32'h00000001);
    check(what, d, exp);
  endtask : rdc
  task automatic stop_test;
    $display("Compared %0d, mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    rdc("select", ADDR_CHAN_SEL, 32'h000000C0);
    rdc("function", ADDR_CHAN_FUNC, 32'h00000302);
    rdc("phase", ADDR_POW, 32'h00000000);
    $display("Test reset done");
    dds_host_model_inst.wr(ADDR_CHAN_SEL, 32'h00000040);
    check("enable0", 32'(chan_en), 32'h00000001);
    dds_host_model_inst.wr(ADDR_POW, 32'h0000FFFF);
    dds_host_model_inst.wr(ADDR_SRR, 32'h0000A55A);
    rdc("phase0", ADDR_POW, 32'h00003FFF);
    check("early", cfg[0].phase_offset_word, 32'h00000000);
    dds_host_model_inst.wr(ADDR_CHAN_SEL, 32'h00000080);
    dds_host_model_inst.wr(ADDR_POW, 32'h00001234);
    rdc("phase1", ADDR_POW, 32'h00001234);
    dds_host_model_inst.upd();
    check("pow0", cfg[0].phase_offset_word, 32'h00003FFF);
    check("pow1", cfg[1].phase_offset_word, 32'h00001234);
    check("rise0", cfg[0].sweep_ramp_rate[7:0], 32'h0000005A);
    check("fall0", cfg[0].sweep_ramp_rate[15:8], 32'h000000A5);
    check("rate1", cfg[1].sweep_ramp_rate, 32'h00000000);
    rdc("function1", ADDR_CHAN_FUNC, 32'h00000300);
    $display("Test banking done");
    exp_step = '{32'h00000000, 32'h00000000};
    // Code 00 comes first, so nothing may land until 01.
    for (int k = 0; k < 4; k++) begin
      dds_host_model_inst.wr(ADDR_CHAN_SEL, {24'h000000, k[1:0], 6'h00});
      dds_host_model_inst.wr(ADDR_RISE_STEP, 32'h5EED0000 + k);
      dds_host_model_inst.upd();
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (k[c]) exp_step[c] = 32'h5EED0000 + k;
        check("step", cfg[c].rising_sweep_step, exp_step[c]);
      end
    end
    rdc("unmapped", 5'h1F, 32'h00000000);
    $display("Test enables done");
    dds_host_model_inst.wr(ADDR_CHAN_SEL, 32'h00000080);
    check("enable1", 32'(chan_en), 32'h00000002);
    dds_host_model_inst.wr(ADDR_FTW, 32'h89ABCDEF);
    dds_host_model_inst.wr(ADDR_AMP_CTRL, 32'hFF123456);
    dds_host_model_inst.wr(ADDR_FALL_STEP, 32'h13579BDF);
    dds_host_model_inst.wr(ADDR_PROF_LAST, 32'hBEEF000F);
    rdc("ftw1", ADDR_FTW, 32'h89ABCDEF);
    rdc("amp1", ADDR_AMP_CTRL, 32'h00123456);
    rdc("fall1", ADDR_FALL_STEP, 32'h13579BDF);
    rdc("prof1", ADDR_PROF_LAST, 32'hBEEF000F);
    dds_host_model_inst.wr(ADDR_CHAN_SEL, 32'h00000040);
    dds_host_model_inst.wr(ADDR_PROF_FIRST, 32'hCAFE0001);
    rdc("prof0", ADDR_PROF_LAST, 32'h00000000);
    check("prof early", prof[0][0], 32'h00000000);
    dds_host_model_inst.upd();
    check("ftw0", cfg[0].frequency_tuning_word, 32'h00000000);
    check("ftw1", cfg[1].frequency_tuning_word, 32'h89ABCDEF);
    check("amp1", 32'(cfg[1].amplitude_control), 32'h00123456);
    check("fall1", cfg[1].falling_sweep_step, 32'h13579BDF);
    check("prof00", prof[0][0], 32'hCAFE0001);
    check("prof10", prof[1][0], 32'h00000000);
    check("prof1last", prof[1][NUM_PROF-1], 32'hBEEF000F);
    $display("Test words done");
    stop_test();
  end
endmodule : dds_channel_bank_bench
